// File: ncu_pkg.sv
// Constants shared by the interrupt unit of the 4-bit controller.
// Assumes an 8-bit I/O address from the CPU core and 4-bit data words.
//
// Function
// [R1] Key flag sets when a key pin is high while its mask bit is 1; the code sets it only when pin AND mask rises.
// [R2] Key request reaches the CPU only with key flag and global enable set.
// [R3] Fast, mid and slow timer rates each have a mask bit gating their flag.
// [R4] Slow and fast stopwatch rates each have a mask bit gating their flag.
// [R5] Vector is driven into the low three bits of the 12-bit PC.
// [R6] Steps on page 1: 01h timer, 02h stopwatch, 04h key, ORed together.
// [R7] Sources sharing a vector bit are told apart by reading the flags.
// [R8] Accepting an interrupt clears the global enable flag.
// [R9] Reading a flag register clears every flag held in it.
// [R10] A timer or stopwatch flag left set, still unmasked, fires again.
// [R11] A key flag left set fires again once interrupts are re-enabled.
// [R12] Software reads the flags only while interrupts are disabled.
// [R13] Timer and stopwatch flags set on their events whatever the masks.
// [R14] The key flag can only be set while the matching mask bit is 1.
// [R15] Setting a key mask bit while its pin is high sets the key flag.
// [R16] Software rewrites key mask bits only while the pin is low.
// [R17] Software copies a shared flag word to RAM before testing bits.
// [R18] Service routines may re-enable interrupts early to allow nesting.
// [R19] Software clears the source flag before re-enabling interrupts.
// [R20] Reading flags while enabled may or may not raise a request.
// [R21] Software puts a jump to its handler at each vector step used.
// [R22] An accepted interrupt wakes the CPU from halt.
// [R23] Timer flags set on a falling edge of their divider tap.
// [R24] Stopwatch flags set on a falling edge of their stopwatch tap.
// [R25] Reset clears all masks and flags; unused bits read as zero.
// [R26] Enable-all and disable-all instructions set and clear global enable.
// [R27] Vector bits are captured at acceptance and held for the fetch.

package ncu_pkg;

    // I/O addresses of the registers
    localparam logic [7:0] ADDR_KEY_MASK = 8'he8;
    localparam logic [7:0] ADDR_SW_MASK = 8'hea;
    localparam logic [7:0] ADDR_TMR_MASK = 8'heb;
    localparam logic [7:0] ADDR_KEY_FLAG = 8'hed;
    localparam logic [7:0] ADDR_SW_FLAG = 8'hee;
    localparam logic [7:0] ADDR_TMR_FLAG = 8'hef;

    // Values after initial reset
    localparam logic [3:0] RST_KEY_MASK = 4'h0;
    localparam logic [1:0] RST_SW_MASK = 2'h0;
    localparam logic [2:0] RST_TMR_MASK = 3'h0;
    localparam logic RST_KEY_FLAG = 1'b0;
    localparam logic [1:0] RST_SW_FLAG = 2'h0;
    localparam logic [2:0] RST_TMR_FLAG = 3'h0;
    localparam logic RST_GLOBAL_EN = 1'b0;

    // Vector layout: page 1, step in the low three bits
    localparam logic [11:0] VEC_PAGE_BASE = 12'h100;
    localparam logic [11:0] RST_VECTOR = 12'h100;
    localparam int VEC_TMR_BIT = 0;
    localparam int VEC_SW_BIT = 1;
    localparam int VEC_KEY_BIT = 2;

    // Tap bit positions: timer 0=32 Hz 1=8 Hz 2=2 Hz, stopwatch 0=10 Hz 1=1 Hz
    localparam int TMR_FAST_BIT = 0;
    localparam int TMR_MID_BIT = 1;
    localparam int TMR_SLOW_BIT = 2;
    localparam int SW_FAST_BIT = 0;
    localparam int SW_SLOW_BIT = 1;

    // Key pin synchroniser depth
    localparam int SYNC_STAGES = 3;

endpackage : ncu_pkg

// File: ncu_pin_sync.sv
// Pin synchroniser for the key inputs.
// Assumes asynchronous pins; a new level is taken once stages two and three
// agree, so a single-cycle glitch never reaches the flag logic.
`timescale 1ns/1ps
`default_nettype none

module ncu_pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock and control
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    // Pins and filtered level
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] held;
    } ncu_sync_t;

    ncu_sync_t st;
    ncu_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.held[i] = st.s3[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
        end else if (clock_en) begin
            st <= next_st;
        end
    end

    assign level_out = st.held;

endmodule : ncu_pin_sync

`default_nettype wire

// File: ncu_intr_unit.sv
// Interrupt unit of the 4-bit controller: masks, factor flags, vector,
// global enable and halt wake-up.
// Assumes the CPU core gives one-cycle pulses for I/O access, enable-all,
// disable-all, halt and instruction boundary, all on the same clock, and
// that timer and stopwatch taps come from logic on this clock.
`timescale 1ns/1ps
`default_nettype none

module ncu_intr_unit (
    // Clock and control
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    // I/O register port from the CPU core
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [3:0] io_wdata,
    output logic [3:0] io_rdata,
    // Instruction events from the CPU core
    input wire logic unmask_all_instruction,
    input wire logic mask_all_instruction,
    input wire logic halt_instruction,
    input wire logic inst_boundary,
    // Event sources
    input wire logic [3:0] key_input_pins,
    input wire logic [2:0] timer_divider_taps,
    input wire logic [1:0] stopwatch_taps,
    // Towards the CPU core
    output logic global_enable,
    output logic cpu_halted,
    output logic int_request,
    output logic int_take,
    output logic [11:0] vector_pc
);

    typedef struct packed {
        logic [3:0] key_mask;
        logic [1:0] sw_mask;
        logic [2:0] tmr_mask;
        logic key_flag;
        logic [1:0] sw_flags;
        logic [2:0] tmr_flags;
        logic [3:0] key_prev;
        logic [1:0] sw_prev;
        logic [2:0] tmr_prev;
        logic ie;
        logic halted;
        logic take;
        logic req;
        logic [11:0] vector;
        logic [3:0] rdata;
    } ncu_state_t;

    ncu_state_t st;
    ncu_state_t next_st;

    logic [3:0] key_level;
    logic [3:0] key_term;
    logic [3:0] key_rise;
    logic [2:0] tmr_fall;
    logic [1:0] sw_fall;
    logic [2:0] pending;
    logic take_now;
    logic rd_key;
    logic rd_sw;
    logic rd_tmr;

    ncu_pin_sync #(
        .WIDTH(4)
    ) u_key_sync (
        .clock(clock),
        .reset(reset),
        .clock_en(clock_en),
        .pin_in(key_input_pins),
        .level_out(key_level)
    );

    // Event detection
    always_comb begin
        // Edge of pin AND mask, so rewriting a mask with the pin high
        // re-arms the flag exactly as the pin rising would
        key_term = key_level & st.key_mask;                 // [R14]
        key_rise = key_term & ~st.key_prev;                 // [R1] [R15]
        tmr_fall = st.tmr_prev & ~timer_divider_taps;       // [R23] [R13]
        sw_fall = st.sw_prev & ~stopwatch_taps;             // [R24] [R13]
        rd_key = io_rd && (io_addr == ncu_pkg::ADDR_KEY_FLAG);
        rd_sw = io_rd && (io_addr == ncu_pkg::ADDR_SW_FLAG);
        rd_tmr = io_rd && (io_addr == ncu_pkg::ADDR_TMR_FLAG);
    end

    // Request forming; sources sharing a bit are not told apart here
    always_comb begin
        pending = 3'h0;
        pending[ncu_pkg::VEC_TMR_BIT] = |(st.tmr_flags & st.tmr_mask); // [R3]
        pending[ncu_pkg::VEC_SW_BIT] = |(st.sw_flags & st.sw_mask);    // [R4]
        pending[ncu_pkg::VEC_KEY_BIT] = st.key_flag;        // [R2] [R7]
        // A flag still set refires as soon as enable returns
        take_now = st.ie && (pending != 3'h0)
            && (inst_boundary || st.halted);                // [R10] [R11]
    end

    always_comb begin
        next_st = st;
        next_st.key_prev = key_term;
        next_st.tmr_prev = timer_divider_taps;
        next_st.sw_prev = stopwatch_taps;

        // Mask writes; reserved bits are not stored
        if (io_wr) begin
            case (io_addr)
                ncu_pkg::ADDR_KEY_MASK: next_st.key_mask = io_wdata;
                ncu_pkg::ADDR_SW_MASK: next_st.sw_mask = io_wdata[1:0];
                ncu_pkg::ADDR_TMR_MASK: next_st.tmr_mask = io_wdata[2:0];
                default: next_st.key_mask = st.key_mask;
            endcase
        end

        // Read data shows the flags as they stand before the clear
        next_st.rdata = 4'h0;                               // [R25]
        if (io_rd) begin
            case (io_addr)
                ncu_pkg::ADDR_KEY_MASK: next_st.rdata = st.key_mask;
                ncu_pkg::ADDR_SW_MASK: next_st.rdata = {2'h0, st.sw_mask};
                ncu_pkg::ADDR_TMR_MASK: next_st.rdata = {1'h0, st.tmr_mask};
                ncu_pkg::ADDR_KEY_FLAG: next_st.rdata = {3'h0, st.key_flag};
                ncu_pkg::ADDR_SW_FLAG: next_st.rdata = {2'h0, st.sw_flags};
                ncu_pkg::ADDR_TMR_FLAG: next_st.rdata = {1'h0, st.tmr_flags};
                default: next_st.rdata = 4'h0;
            endcase
        end

        // Read clears, but an event in the same cycle wins and stays set
        next_st.key_flag = (st.key_flag & ~rd_key) | (|key_rise); // [R9] [R1]
        next_st.sw_flags = (st.sw_flags & ~{2{rd_sw}}) | sw_fall; // [R9] [R24]
        next_st.tmr_flags = (st.tmr_flags & ~{3{rd_tmr}})
            | tmr_fall;                                     // [R9] [R23] [R20]

        // Global enable: disable beats enable, acceptance beats both
        if (unmask_all_instruction) begin
            next_st.ie = 1'b1;                              // [R26]
        end
        if (mask_all_instruction) begin
            next_st.ie = 1'b0;                              // [R26]
        end
        if (halt_instruction) begin
            next_st.halted = 1'b1;
        end

        next_st.take = take_now;
        if (take_now) begin
            next_st.ie = 1'b0;                              // [R8]
            next_st.halted = 1'b0;                          // [R22]
            // Vector frozen here so a flag changing mid-fetch cannot move it
            next_st.vector = ncu_pkg::VEC_PAGE_BASE
                | {9'h000, pending};                        // [R5] [R6] [R27]
        end
        next_st.req = next_st.ie && (pending != 3'h0);      // [R2]
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            st <= '0;
            st.key_mask <= ncu_pkg::RST_KEY_MASK;           // [R25]
            st.sw_mask <= ncu_pkg::RST_SW_MASK;
            st.tmr_mask <= ncu_pkg::RST_TMR_MASK;
            st.key_flag <= ncu_pkg::RST_KEY_FLAG;
            st.sw_flags <= ncu_pkg::RST_SW_FLAG;
            st.tmr_flags <= ncu_pkg::RST_TMR_FLAG;
            st.ie <= ncu_pkg::RST_GLOBAL_EN;
            st.vector <= ncu_pkg::RST_VECTOR;
        end else if (clock_en) begin
            st <= next_st;
        end
    end

    assign io_rdata = st.rdata;
    assign global_enable = st.ie;
    assign cpu_halted = st.halted;
    assign int_request = st.req;
    assign int_take = st.take;
    assign vector_pc = st.vector;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    key_flag_set_a: assert property ( // [R1] [R15]
        clock_en && (key_rise != 4'h0) |=> st.key_flag
    ) else $error("key flag missed a masked pin rise");

    key_gate_a: assert property ( // [R14]
        clock_en && !st.key_flag && (key_rise == 4'h0)
        |=> !st.key_flag
    ) else $error("key flag set without a masked pin rise");

    tmr_fall_a: assert property ( // [R23] [R13] [R20]
        clock_en && (tmr_fall != 3'h0)
        |=> (st.tmr_flags & $past(tmr_fall)) == $past(tmr_fall)
    ) else $error("timer flag missed a falling tap");

    sw_fall_a: assert property ( // [R24] [R13]
        clock_en && (sw_fall != 2'h0)
        |=> (st.sw_flags & $past(sw_fall)) == $past(sw_fall)
    ) else $error("stopwatch flag missed a falling tap");

    flag_clear_a: assert property ( // [R9]
        clock_en && rd_tmr && (tmr_fall == 3'h0)
        |=> st.tmr_flags == 3'h0
    ) else $error("timer flags not cleared by read");

    accept_dis_a: assert property ( // [R8]
        clock_en && take_now |=> !st.ie && int_take && !global_enable
    ) else $error("acceptance left global enable set");

    take_cause_a: assert property ( // [R2] [R3] [R4]
        $rose(int_take) |-> $past(st.ie) && ($past(pending) != 3'h0)
    ) else $error("interrupt taken without enable and request");

    vector_bits_a: assert property ( // [R5] [R6]
        clock_en && take_now
        |=> vector_pc == (12'h100 | {9'h000, $past(pending)})
    ) else $error("vector does not match pending groups");

    vector_hold_a: assert property ( // [R27]
        clock_en && !take_now |=> $stable(vector_pc)
    ) else $error("vector moved without an acceptance");

    wake_a: assert property ( // [R22]
        clock_en && take_now && st.halted |=> !cpu_halted
    ) else $error("acceptance did not wake the CPU");

    refire_a: assert property ( // [R10] [R11]
        clock_en && st.ie && (pending != 3'h0) && inst_boundary
        |=> int_take
    ) else $error("flag still pending did not fire again");

    reserved_zero_a: assert property ( // [R25]
        clock_en && io_rd && (io_addr == ncu_pkg::ADDR_TMR_FLAG)
        |=> io_rdata[3] == 1'b0
    ) else $error("reserved bit read as one");

    key_clear_a: assert property ( // [R9]
        clock_en && rd_key && (key_rise == 4'h0) |=> !st.key_flag
    ) else $error("key flag not cleared by read");

    sw_clear_a: assert property ( // [R9]
        clock_en && rd_sw && (sw_fall == 2'h0) |=> st.sw_flags == 2'h0
    ) else $error("stopwatch flags not cleared by read");

    tmr_keep_a: assert property ( // [R23] [R9]
        clock_en && !rd_tmr && (tmr_fall == 3'h0) |=> $stable(st.tmr_flags)
    ) else $error("timer flags moved without a fall or read");

    sw_keep_a: assert property ( // [R24] [R9]
        clock_en && !rd_sw && (sw_fall == 2'h0) |=> $stable(st.sw_flags)
    ) else $error("stopwatch flags moved without a fall or read");

    key_mask_gate_a: assert property ( // [R14]
        clock_en && (st.key_mask == 4'h0) && !st.key_flag |=> !st.key_flag
    ) else $error("key flag set with every key masked");

    key_mask_wr_a: assert property ( // [R1] [R15]
        clock_en && io_wr && (io_addr == ncu_pkg::ADDR_KEY_MASK)
        |=> st.key_mask == $past(io_wdata)
    ) else $error("key mask write did not land");

    sw_mask_wr_a: assert property ( // [R4]
        clock_en && io_wr && (io_addr == ncu_pkg::ADDR_SW_MASK)
        |=> st.sw_mask == $past(io_wdata[1:0])
    ) else $error("stopwatch mask write did not land");

    tmr_mask_wr_a: assert property ( // [R3]
        clock_en && io_wr && (io_addr == ncu_pkg::ADDR_TMR_MASK)
        |=> st.tmr_mask == $past(io_wdata[2:0])
    ) else $error("timer mask write did not land");

    ie_set_a: assert property ( // [R26]
        clock_en && unmask_all_instruction && !mask_all_instruction
        && !take_now |=> global_enable
    ) else $error("enable-all did not set global enable");

    ie_clear_a: assert property ( // [R26]
        clock_en && mask_all_instruction |=> !global_enable
    ) else $error("disable-all did not clear global enable");

    ie_hold_a: assert property ( // [R26] [R8]
        clock_en && !unmask_all_instruction && !mask_all_instruction
        && !take_now |=> $stable(global_enable)
    ) else $error("global enable moved without a cause");

    take_pulse_a: assert property ( // [R8]
        clock_en && int_take |=> !int_take
    ) else $error("acceptance pulse longer than one cycle");

    take_gate_a: assert property ( // [R2] [R8]
        clock_en && !st.ie |=> !int_take
    ) else $error("interrupt taken while disabled");

    req_off_a: assert property ( // [R2]
        clock_en && !st.ie && !unmask_all_instruction |=> !int_request
    ) else $error("request raised while disabled");

    req_on_a: assert property ( // [R2] [R3] [R4] [R11]
        clock_en && st.ie && (pending != 3'h0) && !take_now
        && !mask_all_instruction |=> int_request
    ) else $error("pending unmasked group raised no request");

    halt_set_a: assert property ( // [R22]
        clock_en && halt_instruction && !take_now |=> cpu_halted
    ) else $error("halt did not stop the CPU");

    halt_hold_a: assert property ( // [R22]
        clock_en && st.halted && !take_now |=> cpu_halted
    ) else $error("CPU left halt without an acceptance");

    rdata_idle_a: assert property ( // [R25]
        clock_en && !io_rd |=> io_rdata == 4'h0
    ) else $error("read data not zero outside a read");

    sw_reserved_a: assert property ( // [R25]
        clock_en && rd_sw |=> io_rdata[3:2] == 2'h0
    ) else $error("stopwatch reserved bits read as one");

    vector_page_a: assert property ( // [R5] [R6]
        vector_pc[11:3] == ncu_pkg::VEC_PAGE_BASE[11:3]
    ) else $error("vector left the vector page");

endmodule : ncu_intr_unit

`default_nettype wire

// File: ncu_cpu_model.sv
// CPU core stand-in: register reads and writes, instruction events.
// Assumes one clock shared with the interrupt unit.
`timescale 1ns/1ps
`default_nettype none

module ncu_cpu_model (
    // Clock
    input wire logic clock,
    // Register port
    output logic [7:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [3:0] io_wdata,
    input wire logic [3:0] io_rdata,
    // Instruction events
    output logic unmask_all_instruction,
    output logic mask_all_instruction,
    output logic halt_instruction,
    output logic inst_boundary,
    // Interrupt side
    input wire logic cpu_halted,
    input wire logic int_take,
    input wire logic [11:0] vector_pc
);
    int takes = 0;
    logic [11:0] jump_pc = 12'h000;

    initial begin
        {io_addr, io_wr, io_rd, io_wdata} = 14'h0000;
        {unmask_all_instruction, mask_all_instruction} = 2'h0;
        halt_instruction = 1'b0;
        inst_boundary = 1'b0;
    end

    // A halted core fetches nothing, so it offers no boundary
    always @(posedge clock) begin
        inst_boundary <= ~cpu_halted;
        if (int_take) begin
            takes <= takes + 1;
            jump_pc <= vector_pc;
        end
    end

    task automatic wr(input logic [7:0] a, input logic [3:0] v);
        @(posedge clock);
        io_addr <= a;
        io_wdata <= v;
        io_wr <= 1'b1;
        @(posedge clock);
        io_wr <= 1'b0;
    endtask : wr

    // Callers read flags only with interrupts off
    task automatic rd(input logic [7:0] a, output logic [3:0] v);
        @(posedge clock);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clock);
        io_rd <= 1'b0;
        #1 v = io_rdata; // Whole word kept before bit
    endtask : rd

    // 1 enable-all, 2 disable-all, 3 halt
    task automatic op(input logic [1:0] k);
        @(posedge clock);
        unmask_all_instruction <= (k == 2'h1);
        mask_all_instruction <= (k == 2'h2);
        halt_instruction <= (k == 2'h3);
        @(posedge clock);
        {unmask_all_instruction, mask_all_instruction} <= 2'h0;
        halt_instruction <= 1'b0;
    endtask : op
endmodule : ncu_cpu_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the interrupt unit with a CPU stand-in.
// Assumes 100 MHz clock; taps and key pins are driven from here.
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] key_input_pins = 4'h0;
    logic [2:0] timer_divider_taps = 3'h7;
    logic [1:0] stopwatch_taps = 2'h3;
    logic [7:0] io_addr;
    logic io_wr, io_rd, global_enable, cpu_halted, int_request, int_take;
    logic [3:0] io_wdata, io_rdata;
    logic unmask_all_instruction, mask_all_instruction;
    logic halt_instruction, inst_boundary;
    logic [11:0] vector_pc;
    int fail_count = 0;
    int tests_run = 0;

    always #5 clock = ~clock;

    ncu_cpu_model i_ncu_cpu_model (.clock, .io_addr, .io_wr, .io_rd,
        .io_wdata, .io_rdata, .unmask_all_instruction,
        .mask_all_instruction, .halt_instruction, .inst_boundary,
        .cpu_halted, .int_take, .vector_pc);
    ncu_intr_unit i_ncu_intr_unit (.clock, .reset, .clock_en(1'b1),
        .io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata,
        .unmask_all_instruction, .mask_all_instruction, .halt_instruction,
        .inst_boundary, .key_input_pins, .timer_divider_taps,
        .stopwatch_taps, .global_enable, .cpu_halted, .int_request,
        .int_take, .vector_pc);

    task automatic check(input logic [11:0] g, e, input string m);
        tests_run++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : check

    task automatic complete_run();
        $display("Counts: %0d compared, %0d failed", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    // Settle time lets a mask write reach the flag logic before a read
    task automatic wr(input logic [7:0] a, input logic [3:0] v);
        i_ncu_cpu_model.wr(a, v);
        repeat (3) @(posedge clock);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [3:0] e,
                          input string m);
        logic [3:0] v;
        i_ncu_cpu_model.rd(a, v);
        check({8'h00, v}, {8'h00, e}, m);
    endtask : rd_chk

    task automatic raise(input logic [2:0] t, input logic [1:0] s,
                         input logic [3:0] k);
        @(posedge clock);
        timer_divider_taps <= ~t;
        stopwatch_taps <= ~s;
        key_input_pins <= k; // Pins rise only from low
        @(posedge clock);
        timer_divider_taps <= 3'h7;
        stopwatch_taps <= 2'h3;
        repeat (8) @(posedge clock);
        key_input_pins <= 4'h0;
        repeat (8) @(posedge clock);
    endtask : raise

    task automatic take(input logic [11:0] v, input string m);
        int n0;
        n0 = i_ncu_cpu_model.takes;
        i_ncu_cpu_model.op(2'h1);
        #1 check({11'h0, int_request}, 12'h001, m);
        for (int n = 0; n < 20 && i_ncu_cpu_model.takes == n0; n++) begin
            @(posedge clock);
            #1;
        end
        check(12'(i_ncu_cpu_model.takes - n0), 12'h001, m);
        check(vector_pc, v, m);
        check(i_ncu_cpu_model.jump_pc, v, m);
        check({10'h0, global_enable, cpu_halted}, 12'h000, m);
    endtask : take

    task automatic test_reset();
        logic [7:0] am [7] = '{8'he8, 8'hea, 8'heb, 8'hed, 8'hee, 8'hef,
                               8'he9};
        #1 check(vector_pc, 12'h100, "reset vector");
        check({9'h0, global_enable, cpu_halted, int_request}, 12'h000,
              "reset outputs");
        foreach (am[i]) rd_chk(am[i], 4'h0, "reset read");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_masks();
        wr(8'he8, 4'hf);
        wr(8'hea, 4'hf);
        wr(8'heb, 4'hf);
        wr(8'hef, 4'hf);
        rd_chk(8'he8, 4'hf, "key mask");
        rd_chk(8'hea, 4'h3, "sw mask");
        rd_chk(8'heb, 4'h7, "tmr mask");
        rd_chk(8'hef, 4'h0, "flag write");
        wr(8'he8, 4'h0);
        wr(8'hea, 4'h0);
        wr(8'heb, 4'h0);
        $display("test_masks done");
    endtask : test_masks

    task automatic test_flags();
        raise(3'h7, 2'h3, 4'h0);
        rd_chk(8'hef, 4'h7, "tmr flags");
        rd_chk(8'hee, 4'h3, "sw flags");
        rd_chk(8'hef, 4'h0, "tmr cleared");
        rd_chk(8'hee, 4'h0, "sw cleared");
        $display("test_flags done");
    endtask : test_flags

    task automatic test_key();
        @(posedge clock);
        key_input_pins <= 4'h2;
        repeat (8) @(posedge clock);
        rd_chk(8'hed, 4'h0, "key masked");
        wr(8'he8, 4'h2);
        rd_chk(8'hed, 4'h1, "mask set high");
        rd_chk(8'hed, 4'h0, "key cleared");
        wr(8'he8, 4'h0);
        wr(8'he8, 4'h2);
        rd_chk(8'hed, 4'h1, "mask reset high");
        @(posedge clock);
        key_input_pins <= 4'h0;
        repeat (8) @(posedge clock);
        $display("test_key done");
    endtask : test_key

    task automatic test_vectors();
        wr(8'he8, 4'hf);
        wr(8'hea, 4'h3);
        wr(8'heb, 4'h7);
        for (int c = 1; c < 8; c++) begin
            raise({3{c[0]}}, {2{c[1]}}, {c[2], 3'h0});
            #1 check({11'h0, int_request}, 12'h000, "held off");
            i_ncu_cpu_model.op(2'h3);
            #1 check({11'h0, cpu_halted}, 12'h001, "halted");
            take(12'h100 | 12'(c), "vector");
            take(12'h100 | 12'(c), "refire");
            rd_chk(8'hef, {1'b0, {3{c[0]}}}, "tmr src");
            rd_chk(8'hee, {2'b0, {2{c[1]}}}, "sw src");
            rd_chk(8'hed, {3'b0, c[2]}, "key src");
            i_ncu_cpu_model.op(2'h1);
            repeat (20) @(posedge clock);
            #1 check({global_enable, int_request}, 12'h002, "idle");
            i_ncu_cpu_model.op(2'h2);
            #1 check({11'h0, global_enable}, 12'h000, "disabled");
        end
        $display("test_vectors done");
    endtask : test_vectors

    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        test_reset();
        test_masks();
        test_flags();
        test_key();
        test_vectors();
        complete_run();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #50000;
        fail_count++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        complete_run();
    end
endmodule : testbench
`default_nettype wire
